// ===== bench/an_arbiter_stub.sv
`timescale 1ns/100ps
// ********************************************************
// arbitration side: received pages and status events
// ********************************************************
module an_arbiter_stub (
    input wire logic i_core_clk,
    output logic o_page_valid,
    output logic [15:0] o_page,
    output logic o_pd_fault,
    output logic o_page_rcvd,
    output logic o_np_able,
    output logic o_an_able
);
    // idle levels; page bus starts parked on a pattern, not on zero
    initial begin
        o_page_valid = 1'b0;
        o_page = 16'hA5A5;
        o_pd_fault = 1'b0;
        o_page_rcvd = 1'b0;
        o_np_able = 1'b0;
        o_an_able = 1'b0;
    end
    // one-cycle page; bus then shows the inverse so stale data cannot pass
    task automatic send_page(input logic [15:0] w);
        @(posedge i_core_clk);
        o_page_valid <= 1'b1;
        o_page <= w;
        @(posedge i_core_clk);
        o_page_valid <= 1'b0;
        o_page <= ~w;
    endtask
    // one-cycle event: 0 parallel detect fault, 1 page received
    task automatic pulse(input logic sel);
        @(posedge i_core_clk);
        o_pd_fault <= ~sel;
        o_page_rcvd <= sel;
        @(posedge i_core_clk);
        o_pd_fault <= 1'b0;
        o_page_rcvd <= 1'b0;
    endtask
    // partner ability levels
    task automatic set_levels(input logic np, input logic an);
        @(posedge i_core_clk);
        o_np_able <= np;
        o_an_able <= an;
    endtask
endmodule

// ===== bench/tb.sv
`timescale 1ns/100ps
// ********************************************************
// status register bank bench
// ********************************************************
module tb
    import autoneg_partner_status_pkg::*;
;
    logic i_core_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [4:0] i_reg_addr = 5'h00;
    logic i_reg_rd = 1'b0;
    logic i_reg_wr = 1'b0;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic pv, pf, pr, npa, ana;
    logic [15:0] pw;
    logic [15:0] o_reg_rdata, o_partner_ability, o_next_page_word;
    logic o_reg_rvalid;
    int error_cnt = 0;
    int samples_checked = 0;

    autoneg_partner_status_regs dut (
        .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
        .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
        .i_base_page_valid(pv), .i_base_page(pw), .i_pd_fault(pf), .i_page_rcvd(pr),
        .i_partner_np_able(npa), .i_partner_an_able(ana), .o_reg_rdata(o_reg_rdata),
        .o_reg_rvalid(o_reg_rvalid), .o_partner_ability(o_partner_ability),
        .o_next_page_word(o_next_page_word));
    an_arbiter_stub u_src (
        .i_core_clk(i_core_clk), .o_page_valid(pv), .o_page(pw), .o_pd_fault(pf),
        .o_page_rcvd(pr), .o_np_able(npa), .o_an_able(ana));

    // 100 MHz clock
    always #5 i_core_clk = ~i_core_clk;

    task automatic chk(input mgmt_word_t got, input mgmt_word_t exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // read strobe one cycle; answer taken at the edge where rvalid is seen
    task automatic rc(input logic [4:0] a, input mgmt_word_t exp, input string what);
        mgmt_word_t d;
        d = 16'hXXXX;
        @(posedge i_core_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        for (int n = 0; n < 4; n++) begin
            @(posedge i_core_clk);
            i_reg_rd <= 1'b0;
            if (o_reg_rvalid === 1'b1) begin
                d = o_reg_rdata;
                break;
            end
        end
        chk(d, exp, what);
    endtask
    task automatic wr(input logic [4:0] a, input mgmt_word_t w);
        @(posedge i_core_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= w;
        @(posedge i_core_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_core_clk);
        error_cnt++;
        summarize();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        rc(5'h05, 16'h0000, "ability reset");
        rc(5'h06, 16'h0004, "expansion reset");
        rc(5'h07, 16'h2001, "next page reset");
        chk(o_next_page_word, 16'h2001, "next page copy");
        $display("test reset done");
        // walking one: every field lands in its own bit, bit 12 never
        for (int i = 0; i < 16; i++) begin
            u_src.send_page(16'h0001 << i);
            rc(5'h05, (16'h0001 << i) & 16'hEFFF, "ability bit");
        end
        u_src.send_page(16'hFFFF);
        rc(5'h05, 16'hEFFF, "ability full");
        chk(o_partner_ability, 16'hEFFF, "ability copy");
        $display("test page load done");
        u_src.pulse(1'b0);
        rc(5'h06, 16'h0014, "fault set");
        rc(5'h06, 16'h0004, "fault cleared");
        u_src.pulse(1'b1);
        rc(5'h06, 16'h0006, "page set");
        rc(5'h06, 16'h0004, "page cleared");
        u_src.set_levels(1'b1, 1'b0);
        rc(5'h06, 16'h000C, "partner np");
        u_src.set_levels(1'b0, 1'b1);
        rc(5'h06, 16'h0005, "partner an");
        u_src.set_levels(1'b0, 1'b0);
        // event on the very edge of the clearing read: set must survive
        fork
            u_src.pulse(1'b1);
            rc(5'h06, 16'h0004, "read at set");
        join
        rc(5'h06, 16'h0006, "set wins");
        $display("test expansion done");
        wr(5'h07, 16'hFFFF);
        rc(5'h07, 16'hBFFF, "next page write");
        chk(o_next_page_word, 16'hBFFF, "next page copy");
        wr(5'h05, 16'h0000);
        rc(5'h05, 16'hEFFF, "ability read only");
        wr(5'h06, 16'hFFFF);
        rc(5'h06, 16'h0004, "expansion read only");
        wr(5'h1F, 16'hFFFF);
        rc(5'h1F, 16'h0000, "unmapped");
        $display("test writes done");
        // mid-run reset with a pending flag and loaded registers
        u_src.pulse(1'b0);
        @(posedge i_core_clk);
        i_resetn <= 1'b0;
        @(posedge i_core_clk);
        i_resetn <= 1'b1;
        rc(5'h06, 16'h0004, "expansion rereset");
        rc(5'h07, 16'h2001, "next page rereset");
        rc(5'h05, 16'h0000, "ability rereset");
        $display("test second reset done");
        summarize();
    end
endmodule

// ===== rtl/anps_sticky_flag.sv
`timescale 1ns/100ps
`include "autoneg_partner_status_defines.svh"

// ********************************************************
// sticky event flag, cleared by a register read
// ********************************************************
module anps_sticky_flag
    import autoneg_partner_status_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_set,
    input wire logic i_clr,
    output logic o_flag
);

    logic flag_q;

    // set wins over clear so an event during the read is kept
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            flag_q <= 1'b0;
        end else if (i_set) begin
            flag_q <= 1'b1;
        end else if (i_clr) begin
            flag_q <= 1'b0;
        end
    end

    assign o_flag = flag_q;

    property p_set_wins;
        @(posedge i_core_clk) disable iff (!i_resetn)
        i_set |=> flag_q;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("sticky flag lost an event");

    property p_clear_on_read;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_clr && !i_set) |=> !flag_q ##1 ($past(i_set) || !flag_q);
    endproperty
    a_clear_on_read: assert property (p_clear_on_read)
        else $error("sticky flag not cleared by read");

endmodule

// ===== rtl/autoneg_partner_status_defines.svh
`ifndef AUTONEG_PARTNER_STATUS_DEFINES_SVH
`define AUTONEG_PARTNER_STATUS_DEFINES_SVH

// ********************************************************
// management register offsets
// ********************************************************
`define ANPS_ADDR_W 5
`define ANPS_OFS_LINK_PARTNER_ABILITY 5'h05
`define ANPS_OFS_AUTONEG_EXPANSION 5'h06
`define ANPS_OFS_NEXT_PAGE_TRANSMIT 5'h07

// ********************************************************
// reset values
// ********************************************************
`define ANPS_RST_LINK_PARTNER_ABILITY 16'h0000
`define ANPS_RST_AUTONEG_EXPANSION 16'h0004
`define ANPS_RST_NEXT_PAGE_TRANSMIT 16'h2001

// ********************************************************
// field positions
// ********************************************************
`define ANPS_LPA_NEXT_PAGE 15
`define ANPS_LPA_ACK 14
`define ANPS_LPA_REMOTE_FAULT 13
`define ANPS_LPA_RSVD 12
`define ANPS_LPA_ASYM_PAUSE 11
`define ANPS_LPA_PAUSE 10
`define ANPS_LPA_T4 9
`define ANPS_LPA_TX_FD 8
`define ANPS_LPA_TX_HD 7
`define ANPS_LPA_10_FD 6
`define ANPS_LPA_10_HD 5
`define ANPS_LPA_SEL_HI 4
`define ANPS_LPA_SEL_LO 0
`define ANPS_SEL_ETHERNET 5'h01
`define ANPS_EXP_PD_FAULT 4
`define ANPS_EXP_LP_NP_ABLE 3
`define ANPS_EXP_LOC_NP_ABLE 2
`define ANPS_EXP_PAGE_RCVD 1
`define ANPS_EXP_LP_AN_ABLE 0
`define ANPS_NPT_RSVD 14

// ********************************************************
// writable / readable masks
// ********************************************************
`define ANPS_LPA_MASK 16'hEFFF
`define ANPS_NPT_MASK 16'hBFFF

// ********************************************************
// sticky flag count (fault, page received)
// ********************************************************
`define ANPS_NUM_STICKY 2
`define ANPS_STICKY_FAULT 0
`define ANPS_STICKY_PAGE 1

`endif

// ===== rtl/autoneg_partner_status_pkg.sv
package autoneg_partner_status_pkg;

    typedef logic [15:0] mgmt_word_t;

    // one-hot register select from address decode
    typedef enum logic [3:0] {
        SEL_NONE = 4'b0001,
        SEL_LPA = 4'b0010,
        SEL_EXP = 4'b0100,
        SEL_NPT = 4'b1000
    } reg_sel_t;

endpackage

// ===== rtl/autoneg_partner_status_regs.sv
`timescale 1ns/100ps
`include "autoneg_partner_status_defines.svh"

module autoneg_partner_status_regs
    import autoneg_partner_status_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [`ANPS_ADDR_W-1:0] i_reg_addr,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_base_page_valid,
    input wire logic [15:0] i_base_page,
    input wire logic i_pd_fault,
    input wire logic i_page_rcvd,
    input wire logic i_partner_np_able,
    input wire logic i_partner_an_able,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic [15:0] o_partner_ability,
    output logic [15:0] o_next_page_word
);

    // ********************************************************
    // address decode
    // ********************************************************
    reg_sel_t sel;
    always_comb begin
        case (i_reg_addr)
            `ANPS_OFS_LINK_PARTNER_ABILITY: sel = SEL_LPA;
            `ANPS_OFS_AUTONEG_EXPANSION: sel = SEL_EXP;
            `ANPS_OFS_NEXT_PAGE_TRANSMIT: sel = SEL_NPT;
            default: sel = SEL_NONE;
        endcase
    end

    // ********************************************************
    // link partner ability
    // ********************************************************
    mgmt_word_t lpa_q;

    // whole word taken at once so fields never mix two pages
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lpa_q <= `ANPS_RST_LINK_PARTNER_ABILITY;
        end else if (i_base_page_valid) begin
            lpa_q <= i_base_page & `ANPS_LPA_MASK;
        end
    end

    // ********************************************************
    // expansion flags
    // ********************************************************
    logic exp_rd;
    logic [`ANPS_NUM_STICKY-1:0] sticky_set;
    logic [`ANPS_NUM_STICKY-1:0] sticky_flag;
    logic loc_np_able_q;
    mgmt_word_t exp_word;
    // whole reset word kept so the local bit is picked out, not truncated
    localparam mgmt_word_t exp_rst_word = `ANPS_RST_AUTONEG_EXPANSION;

    assign exp_rd = i_reg_rd && (sel == SEL_EXP);
    assign sticky_set[`ANPS_STICKY_FAULT] = i_pd_fault;
    assign sticky_set[`ANPS_STICKY_PAGE] = i_page_rcvd;

    // one latching flag per hardware event
    genvar gi;
    generate
        for (gi = 0; gi < `ANPS_NUM_STICKY; gi++) begin : g_sticky
            anps_sticky_flag u_flag (
                .i_core_clk(i_core_clk),
                .i_resetn(i_resetn),
                .i_set(sticky_set[gi]),
                .i_clr(exp_rd),
                .o_flag(sticky_flag[gi])
            );
        end
    endgenerate

    // local next-page support is fixed; held in a flop for its reset value
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            loc_np_able_q <= exp_rst_word[`ANPS_EXP_LOC_NP_ABLE];
        end else begin
            loc_np_able_q <= 1'b1;
        end
    end

    // upper bits tie to zero
    always_comb begin
        exp_word = 16'h0000;
        exp_word[`ANPS_EXP_PD_FAULT] = sticky_flag[`ANPS_STICKY_FAULT];
        exp_word[`ANPS_EXP_LP_NP_ABLE] = i_partner_np_able;
        exp_word[`ANPS_EXP_LOC_NP_ABLE] = loc_np_able_q;
        exp_word[`ANPS_EXP_PAGE_RCVD] = sticky_flag[`ANPS_STICKY_PAGE];
        exp_word[`ANPS_EXP_LP_AN_ABLE] = i_partner_an_able;
    end

    // ********************************************************
    // next page transmit
    // ********************************************************
    mgmt_word_t npt_q;

    // reserved bit 14 is not stored, so it always reads zero
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            npt_q <= `ANPS_RST_NEXT_PAGE_TRANSMIT;
        end else if (i_reg_wr && (sel == SEL_NPT)) begin
            npt_q <= i_reg_wdata & `ANPS_NPT_MASK;
        end
    end

    // ********************************************************
    // read port
    // ********************************************************
    mgmt_word_t rd_mux;
    always_comb begin
        case (sel)
            SEL_LPA: rd_mux = lpa_q;
            SEL_EXP: rd_mux = exp_word;
            SEL_NPT: rd_mux = npt_q;
            SEL_NONE: rd_mux = 16'h0000;
            default: rd_mux = 16'h0000;
        endcase
    end

    // data is the value before the clear-on-read takes effect
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reg_rdata <= 16'h0000;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rd_mux;
            end
        end
    end

    // registered copies for the arbitration logic
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_partner_ability <= `ANPS_RST_LINK_PARTNER_ABILITY;
            o_next_page_word <= `ANPS_RST_NEXT_PAGE_TRANSMIT;
        end else begin
            o_partner_ability <= lpa_q;
            o_next_page_word <= npt_q;
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    logic rd_lpa;
    assign rd_lpa = i_reg_rd && (sel == SEL_LPA);

    property p_np_bit;
        @(posedge i_core_clk) disable iff (!i_resetn)
        i_base_page_valid ##1 rd_lpa |=>
            o_reg_rdata[`ANPS_LPA_NEXT_PAGE] == $past(i_base_page[`ANPS_LPA_NEXT_PAGE], 2);
    endproperty
    a_np_bit: assert property (p_np_bit)
        else $error("partner next page bit wrong");

    property p_ack_bit;
        @(posedge i_core_clk) disable iff (!i_resetn)
        i_base_page_valid |=> lpa_q[`ANPS_LPA_ACK] == $past(i_base_page[`ANPS_LPA_ACK]);
    endproperty
    a_ack_bit: assert property (p_ack_bit)
        else $error("partner acknowledge bit wrong");

    property p_rf_bit;
        @(posedge i_core_clk) disable iff (!i_resetn)
        i_base_page_valid |=> ##1
            o_partner_ability[`ANPS_LPA_REMOTE_FAULT] == $past(i_base_page[13], 2);
    endproperty
    a_rf_bit: assert property (p_rf_bit)
        else $error("partner remote fault bit wrong");

    property p_pause_bits;
        @(posedge i_core_clk) disable iff (!i_resetn)
        i_base_page_valid |=> lpa_q[11:10] == $past(i_base_page[11:10]);
    endproperty
    a_pause_bits: assert property (p_pause_bits)
        else $error("partner pause bits wrong");

    property p_tech_bits;
        @(posedge i_core_clk) disable iff (!i_resetn)
        i_base_page_valid |=> lpa_q[9:5] == $past(i_base_page[9:5]);
    endproperty
    a_tech_bits: assert property (p_tech_bits)
        else $error("partner technology bits wrong");

    property p_selector;
        @(posedge i_core_clk) disable iff (!i_resetn)
        i_base_page_valid |=> lpa_q[4:0] == $past(i_base_page[4:0]);
    endproperty
    a_selector: assert property (p_selector)
        else $error("partner selector wrong");

    property p_lpa_hold;
        @(posedge i_core_clk) disable iff (!i_resetn)
        !i_base_page_valid |=> $stable(lpa_q) && !lpa_q[`ANPS_LPA_RSVD];
    endproperty
    a_lpa_hold: assert property (p_lpa_hold)
        else $error("partner ability changed without a page");

    property p_fault_read;
        @(posedge i_core_clk) disable iff (!i_resetn)
        i_pd_fault ##1 exp_rd |=> o_reg_rdata[`ANPS_EXP_PD_FAULT] && o_reg_rdata[15:5] == 11'h000;
    endproperty
    a_fault_read: assert property (p_fault_read)
        else $error("fault flag not read back");

    property p_page_read;
        @(posedge i_core_clk) disable iff (!i_resetn)
        i_page_rcvd ##1 exp_rd |=> o_reg_rdata[`ANPS_EXP_PAGE_RCVD];
    endproperty
    a_page_read: assert property (p_page_read)
        else $error("page received flag not read back");

    property p_exp_levels;
        @(posedge i_core_clk) disable iff (!i_resetn)
        exp_rd |=> o_reg_rdata[`ANPS_EXP_LP_NP_ABLE] == $past(i_partner_np_able)
            && o_reg_rdata[`ANPS_EXP_LP_AN_ABLE] == $past(i_partner_an_able)
            && o_reg_rdata[`ANPS_EXP_LOC_NP_ABLE];
    endproperty
    a_exp_levels: assert property (p_exp_levels)
        else $error("expansion ability bits wrong");

    property p_npt_write;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_reg_wr && i_reg_addr == 5'h07) |=> ##1 o_next_page_word == ($past(i_reg_wdata, 2) & 16'hBFFF);
    endproperty
    a_npt_write: assert property (p_npt_write)
        else $error("next page word write lost");

    property p_exp_rsvd_zero;
        @(posedge i_core_clk) disable iff (!i_resetn)
        exp_rd |=> o_reg_rdata[15:5] == 11'h000;
    endproperty
    a_exp_rsvd_zero: assert property (p_exp_rsvd_zero)
        else $error("expansion reserved bits not zero");

    property p_lpa_rsvd_read;
        @(posedge i_core_clk) disable iff (!i_resetn)
        rd_lpa |=> !o_reg_rdata[`ANPS_LPA_RSVD];
    endproperty
    a_lpa_rsvd_read: assert property (p_lpa_rsvd_read)
        else $error("partner reserved bit read as one");

    property p_fault_clear;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (exp_rd && !i_pd_fault) |=> !sticky_flag[`ANPS_STICKY_FAULT];
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("fault flag survived a read");

    property p_page_clear;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (exp_rd && !i_page_rcvd) |=> !sticky_flag[`ANPS_STICKY_PAGE];
    endproperty
    a_page_clear: assert property (p_page_clear)
        else $error("page flag survived a read");

    property p_fault_quiet;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (!i_pd_fault && !sticky_flag[`ANPS_STICKY_FAULT]) |=> !sticky_flag[`ANPS_STICKY_FAULT];
    endproperty
    a_fault_quiet: assert property (p_fault_quiet)
        else $error("fault flag set without an event");

    property p_page_quiet;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (!i_page_rcvd && !sticky_flag[`ANPS_STICKY_PAGE]) |=> !sticky_flag[`ANPS_STICKY_PAGE];
    endproperty
    a_page_quiet: assert property (p_page_quiet)
        else $error("page flag set without an event");

    property p_npt_hold;
        @(posedge i_core_clk) disable iff (!i_resetn)
        !(i_reg_wr && (sel == SEL_NPT)) |=> $stable(npt_q);
    endproperty
    a_npt_hold: assert property (p_npt_hold)
        else $error("next page word changed without a write");

    property p_npt_rsvd;
        @(posedge i_core_clk) disable iff (!i_resetn)
        !npt_q[`ANPS_NPT_RSVD];
    endproperty
    a_npt_rsvd: assert property (p_npt_rsvd)
        else $error("next page reserved bit stored");

endmodule
